// *** rtl/ppl_defs.vh ***
// Purpose: shared constants of the printer port pin logic
// Assumes: included by bare name from rtl/ppl_port.v
// Notes:   bit positions, mode codes, reset values and fifo shape
`ifndef PPL_DEFS_VH
`define PPL_DEFS_VH

// control register fields
`define PPL_CTRL_STROBE_BIT   0
`define PPL_CTRL_AUTOFD_BIT   1
`define PPL_CTRL_INIT_BIT     2
`define PPL_CTRL_SELECT_BIT   3
`define PPL_CTRL_DIR_BIT      4
`define PPL_CTRL_WIDTH        5
// init bit resets low: printer is held in initialise until software releases it
`define PPL_CTRL_RESET        5'h00

// status register fields
`define PPL_STAT_FAULT_BIT    3
`define PPL_STAT_ONLINE_BIT   4
`define PPL_STAT_PAPER_BIT    5
`define PPL_STAT_ACK_BIT      6
`define PPL_STAT_NBUSY_BIT    7
`define PPL_STAT_RESET        8'h00

// port modes
`define PPL_MODE_STD          2'h0
`define PPL_MODE_EPP          2'h1
`define PPL_MODE_ECP          2'h2

// data path
`define PPL_DATA_WIDTH        8
`define PPL_FIFO_DEPTH        16
`define PPL_FIFO_AW           4
`define PPL_DATA_RESET        8'h00

`endif

// *** rtl/ppl_fifo.v ***
// Purpose: parameterised fifo with registered read data for the port data path
// Assumes: single clock, asynchronous active-low reset
// Notes:   holds DEPTH words in memory plus one in the output register
`timescale 1ns/1ps
`default_nettype none

module ppl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             core_clk_in,
  input  wire             resetn_in,
  // fill side
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  // drain side
  output reg              out_valid_out,
  output reg  [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in,
  // fill level of the memory part
  output reg  [AW:0]      level_out
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  wire             push;
  wire             pop;
  wire             load;

  // full only when every memory word is taken
  assign in_ready_out = (level_out != DEPTH[AW:0]);
  assign push         = in_valid_in & in_ready_out;
  assign pop          = out_valid_out & out_ready_in;
  assign load         = (level_out != {(AW+1){1'b0}}) & (~out_valid_out | pop);

  // memory write port, no reset on storage
  always @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers, level and registered read stage
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr        <= {AW{1'b0}};
      rd_ptr        <= {AW{1'b0}};
      level_out     <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        rd_ptr       <= rd_ptr + 1'b1;
        out_data_out <= mem[rd_ptr];
      end
      if (push & ~load) begin
        level_out <= level_out + 1'b1;
      end else if (load & ~push) begin
        level_out <= level_out - 1'b1;
      end
      if (load) begin
        out_valid_out <= 1'b1;
      end else if (pop) begin
        out_valid_out <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/ppl_port.v ***
// Purpose: pin-level logic of a printer parallel port, standard mode plus alternate pins and EPP stretch in enhanced modes
// Assumes: host logic on core_clk_in (40 MHz); printer pins are asynchronous
// Notes:   control and status are plain ports, outbound bytes pass a 17-word fifo (16 in memory, one in the output register)
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defs.vh"

module ppl_port (
  // clock and reset
  input  wire                        core_clk_in,
  input  wire                        resetn_in,
  // control register write port
  input  wire                        ctrl_wr_in,
  input  wire [`PPL_CTRL_WIDTH-1:0]  ctrl_data_in,
  output reg  [`PPL_CTRL_WIDTH-1:0]  ctrl_out,
  // mode and alternate control lines for enhanced modes
  input  wire [1:0]                  port_mode_in,
  input  wire [3:0]                  alt_ctrl_in,
  // status register read value
  output reg  [7:0]                  status_out,
  // outbound byte stream from host
  input  wire                        tx_valid_in,
  input  wire [`PPL_DATA_WIDTH-1:0]  tx_data_in,
  output reg                         tx_ready_out,
  // inbound byte sampled from the cable
  output reg  [`PPL_DATA_WIDTH-1:0]  rx_data_out,
  // host cycle in progress (EPP) and open-drain channel ready
  input  wire                        host_cycle_in,
  output reg                         channel_ready_out,
  output reg                         channel_ready_oe_out,
  // printer control pins
  output reg                         printer_select_out,
  output reg                         printer_init_out,
  output reg                         auto_line_feed_out,
  output reg                         data_strobe_out,
  // printer status pins
  input  wire                        busy_in,
  input  wire                        printer_ack_in,
  input  wire                        paper_out_in,
  input  wire                        printer_online_in,
  input  wire                        printer_fault_in,
  // two-way data lines
  input  wire [`PPL_DATA_WIDTH-1:0]  port_data_lines_in,
  output reg  [`PPL_DATA_WIDTH-1:0]  port_data_lines_out,
  output reg                         port_data_lines_oe_out
);

  // synchroniser stages: first stage read only by the second
  reg  [12:0]                 pin_meta;
  reg  [12:0]                 pin_sync;
  wire                        busy_s;
  wire                        ack_s;
  wire                        paper_s;
  wire                        online_s;
  wire                        fault_s;
  wire [`PPL_DATA_WIDTH-1:0]  data_s;

  // fifo connections
  wire                        fifo_in_ready;
  wire                        fifo_out_valid;
  wire [`PPL_DATA_WIDTH-1:0]  fifo_out_data;
  wire                        fifo_out_ready;
  wire [`PPL_FIFO_AW:0]       fifo_level;

  // next values
  reg  [`PPL_CTRL_WIDTH-1:0]  next_ctrl;
  reg  [3:0]                  next_pins;
  reg                         next_stretch;
  reg                         byte_shown;
  wire                        enhanced;
  wire                        drive_out;

  // two flip-flops on every asynchronous pin input
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta <= 13'h0000;
      pin_sync <= 13'h0000;
    end else begin
      pin_meta <= {port_data_lines_in, printer_fault_in, printer_online_in,
                   paper_out_in, printer_ack_in, busy_in};
      pin_sync <= pin_meta;
    end
  end

  assign busy_s   = pin_sync[0];
  assign ack_s    = pin_sync[1];
  assign paper_s  = pin_sync[2];
  assign online_s = pin_sync[3];
  assign fault_s  = pin_sync[4];
  assign data_s   = pin_sync[12:5];

  assign enhanced  = (port_mode_in == `PPL_MODE_EPP) | (port_mode_in == `PPL_MODE_ECP);
  assign drive_out = ~ctrl_out[`PPL_CTRL_DIR_BIT];

  // control register: a write lands in the next edge
  always @* begin
    next_ctrl = ctrl_out;
    if (ctrl_wr_in) begin
      next_ctrl = ctrl_data_in;
    end
  end

  // pin values derived from the next control value in standard mode so pins move with the register; enhanced modes take alt_ctrl_in
  always @* begin
    if (enhanced) begin
      next_pins = alt_ctrl_in;
    end else begin
      next_pins[3] = ~next_ctrl[`PPL_CTRL_SELECT_BIT];
      next_pins[2] =  next_ctrl[`PPL_CTRL_INIT_BIT];
      next_pins[1] = ~next_ctrl[`PPL_CTRL_AUTOFD_BIT];
      next_pins[0] = ~next_ctrl[`PPL_CTRL_STROBE_BIT];
    end
  end

  // control register and control pins
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_out           <= `PPL_CTRL_RESET;
      printer_select_out <= 1'b1;
      printer_init_out   <= 1'b0;
      auto_line_feed_out <= 1'b1;
      data_strobe_out    <= 1'b1;
    end else begin
      ctrl_out           <= next_ctrl;
      printer_select_out <= next_pins[3];
      printer_init_out   <= next_pins[2];
      auto_line_feed_out <= next_pins[1];
      data_strobe_out    <= next_pins[0];
    end
  end

  // status register from synchronised pins; bits 2..0 read zero
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= `PPL_STAT_RESET;
    end else begin
      status_out                      <= 8'h00;
      status_out[`PPL_STAT_NBUSY_BIT] <= ~busy_s;
      status_out[`PPL_STAT_ACK_BIT]   <= ack_s;
      status_out[`PPL_STAT_PAPER_BIT] <= paper_s;
      status_out[`PPL_STAT_ONLINE_BIT] <= online_s;
      status_out[`PPL_STAT_FAULT_BIT] <= fault_s;
    end
  end

  // outbound byte buffer
  ppl_fifo #(
    .WIDTH (`PPL_DATA_WIDTH),
    .DEPTH (`PPL_FIFO_DEPTH),
    .AW    (`PPL_FIFO_AW)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_data_in),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_out_ready),
    .level_out     (fifo_level)
  );

  // one byte per strobe: a shown byte stays on the lines until software pulses the strobe bit
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      byte_shown <= 1'b0;
    end else if (fifo_out_valid & fifo_out_ready) begin
      byte_shown <= 1'b1;
    end else if (ctrl_out[`PPL_CTRL_STROBE_BIT]) begin
      byte_shown <= 1'b0;
    end
  end

  // a byte moves to the lines only while driving, printer idle, strobe released, last one strobed
  assign fifo_out_ready = drive_out & ~busy_s & ~ctrl_out[`PPL_CTRL_STROBE_BIT] &
                          ~byte_shown;

  // data lines: drive from the buffer or sample the cable
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_data_lines_out    <= `PPL_DATA_RESET;
      port_data_lines_oe_out <= 1'b0;
      rx_data_out            <= `PPL_DATA_RESET;
      tx_ready_out           <= 1'b0;
    end else begin
      port_data_lines_oe_out <= next_ctrl[`PPL_CTRL_DIR_BIT] == 1'b0;
      if (fifo_out_valid & fifo_out_ready) begin
        port_data_lines_out <= fifo_out_data;
      end
      rx_data_out  <= data_s;
      tx_ready_out <= fifo_in_ready & ~(tx_valid_in & (fifo_level == 5'h0f));
    end
  end

  // stretch a host cycle in EPP mode while the buffer cannot take a byte
  always @* begin
    next_stretch = 1'b0;
    if ((port_mode_in == `PPL_MODE_EPP) & host_cycle_in) begin
      next_stretch = ~fifo_in_ready | ~tx_ready_out;
    end
  end

  // open drain: only ever drives low, pull-up holds it high otherwise
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_ready_out    <= 1'b0;
      channel_ready_oe_out <= 1'b0;
    end else begin
      channel_ready_out    <= 1'b0;
      channel_ready_oe_out <= next_stretch;
    end
  end

endmodule

`default_nettype wire

// *** rtl/ppl_port_fix_note.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** testbench/ppl_printer_model.sv ***
// Purpose: printer on the cable, answers a strobe with busy and an ack pulse
// Assumes: strobe stays low for at least one clock
// Notes:   hold_in keeps busy up so the port stalls
`timescale 1ns/1ps
`default_nettype none
module ppl_printer_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // port side
  input  wire logic       strobe_n_in,
  input  wire logic       hold_in,
  input  wire logic       dut_oe_in,
  input  wire logic [7:0] dut_data_in,
  input  wire logic [7:0] drive_byte_in,
  // printer pins
  output logic            busy_out,
  output logic            ack_n_out,
  output logic [7:0]      data_out
);
  logic [3:0] cnt;
  // wire level: the port when it drives, else the printer
  assign data_out = dut_oe_in ? dut_data_in : drive_byte_in;
  // busy from strobe until the same edge that ends the ack pulse
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_out  <= 1'b0;
      ack_n_out <= 1'b1;
      cnt       <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt       <= cnt - 4'h1;
      ack_n_out <= cnt != 4'h3;
      busy_out  <= cnt > 4'h2 || hold_in;
    end else begin
      busy_out  <= !strobe_n_in || hold_in;
      if (!strobe_n_in) cnt <= 4'h8;
    end
  end
endmodule
`default_nettype wire

// *** testbench/ppl_port_sva.sv ***
// Purpose: assertion checker bound to ppl_port
// Assumes: control pin and data enable checks only in standard mode
// Notes:   status pins take three edges to show
`timescale 1ns/1ps
`default_nettype none
module ppl_port_sva (
  // clock, reset and host side
  input wire logic       core_clk_in,
  input wire logic       resetn_in,
  input wire logic       ctrl_wr_in,
  input wire logic [4:0] ctrl_data_in,
  input wire logic [4:0] ctrl_out,
  input wire logic [1:0] port_mode_in,
  input wire logic       host_cycle_in,
  input wire logic [7:0] status_out,
  input wire logic       channel_ready_out,
  input wire logic       channel_ready_oe_out,
  // printer pins
  input wire logic       printer_select_out,
  input wire logic       printer_init_out,
  input wire logic       auto_line_feed_out,
  input wire logic       data_strobe_out,
  input wire logic       busy_in,
  input wire logic       printer_ack_in,
  input wire logic       paper_out_in,
  input wire logic       printer_online_in,
  input wire logic       printer_fault_in,
  input wire logic       port_data_lines_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [2:0] warm;
  // edges since reset, so the synchroniser is full before status checks
  always @(posedge core_clk_in or negedge resetn_in)
    if (!resetn_in) warm <= 3'h0;
    else if (warm != 3'h7) warm <= warm + 3'h1;
  sequence s_std_wr;
    ctrl_wr_in && port_mode_in == 2'h0;
  endsequence
  sequence s_std_idle;
    !ctrl_wr_in && port_mode_in == 2'h0;
  endsequence
  a_select_inv: assert property (s_std_wr |=> printer_select_out == !$past(ctrl_data_in[3]))
    else $error("select pin is not inverted bit 3");
  a_init_direct: assert property (s_std_wr |=> printer_init_out == $past(ctrl_data_in[2]))
    else $error("init pin does not follow bit 2");
  a_feed_inv: assert property (s_std_wr |=> auto_line_feed_out != ctrl_out[1])
    else $error("feed pin is not inverted bit 1");
  a_strobe_hold: assert property (s_std_wr ##1 s_std_idle [*2] |-> data_strobe_out == !ctrl_out[0])
    else $error("strobe pin is not inverted bit 0");
  a_busy_inv: assert property (warm == 3'h7 |-> status_out[7] == !$past(busy_in, 3))
    else $error("status bit 7 is not inverted busy");
  a_ack_level: assert property (warm == 3'h7 |-> status_out[6] == $past(printer_ack_in, 3))
    else $error("status bit 6 differs from ack");
  a_paper_level: assert property (warm == 3'h7 |-> status_out[5] == $past(paper_out_in, 3))
    else $error("status bit 5 differs from paper");
  a_online_fault: assert property (warm == 3'h7 |-> status_out[4] == $past(printer_online_in, 3)
      && status_out[3] == $past(printer_fault_in, 3))
    else $error("status bits 4 or 3 differ from pins");
  a_stretch_cause: assert property (channel_ready_oe_out |-> $past(port_mode_in) == 2'h1
      && $past(host_cycle_in) && !channel_ready_out)
    else $error("ready line pulled outside an EPP cycle");
  a_dir_drive: assert property (warm == 3'h7 && $stable(ctrl_out[4]) && $stable(port_mode_in)
      && port_mode_in == 2'h0 |-> port_data_lines_oe_out == !ctrl_out[4])
    else $error("data enable disagrees with direction");
endmodule
bind ppl_port ppl_port_sva i_sva (.*);
`default_nettype wire

// *** testbench/ppl_port_bench.sv ***
// Purpose: self-checking bench for ppl_port
// Assumes: 40 MHz clock, printer model on the cable
// Notes:   scenario tasks run in order
`timescale 1ns/1ps
`default_nettype none
module ppl_port_bench;
  logic       core_clk_in = 1'b0, resetn_in = 1'b0, ctrl_wr_in = 1'b0, tx_valid_in = 1'b0;
  logic       host_cycle_in = 1'b0, hold = 1'b0, paper_out_in = 1'b0;
  logic       printer_online_in = 1'b1, printer_fault_in = 1'b1;
  logic [4:0] ctrl_data_in = 5'h00, ctrl_out;
  logic [1:0] port_mode_in = 2'h0;
  logic [3:0] alt_ctrl_in = 4'hb;
  logic [7:0] tx_data_in = 8'h00, drive_byte = 8'h00, status_out, rx_data_out;
  logic [7:0] port_data_lines_in, port_data_lines_out;
  logic       tx_ready_out, channel_ready_out, channel_ready_oe_out, printer_select_out;
  logic       printer_init_out, auto_line_feed_out, data_strobe_out, busy_in;
  logic       printer_ack_in, port_data_lines_oe_out;
  logic [7:0] pat [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
  int         failures = 0, n_compared = 0, cycles = 0, n;
  ppl_port i_dut (.*);
  ppl_printer_model i_printer (.clk_in(core_clk_in), .resetn_in(resetn_in),
    .strobe_n_in(data_strobe_out), .hold_in(hold), .dut_oe_in(port_data_lines_oe_out),
    .dut_data_in(port_data_lines_out), .drive_byte_in(drive_byte), .busy_out(busy_in),
    .ack_n_out(printer_ack_in), .data_out(port_data_lines_in));
  always #12.5 core_clk_in = !core_clk_in;
  // cut a hung run short
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_in);
  endtask
  task automatic wr_ctrl(input logic [4:0] v);
    @(posedge core_clk_in);
    ctrl_wr_in   <= 1'b1;
    ctrl_data_in <= v;
    @(posedge core_clk_in);
    ctrl_wr_in   <= 1'b0;
  endtask
  // back-to-back writes of every pin pattern
  task automatic t_ctrl_pins();
    for (int i = 0; i <= 16; i++) begin
      @(posedge core_clk_in);
      ctrl_wr_in   <= i < 16;
      ctrl_data_in <= 5'(i);
      if (i > 0) begin
        @(negedge core_clk_in);
        chk({4'h0, printer_select_out, printer_init_out, auto_line_feed_out,
             data_strobe_out}, 8'(i - 1) ^ 8'h0b);
        chk({3'h0, ctrl_out}, 8'(i - 1));
      end
    end
  endtask
  // every level of busy, paper, online and fault through the synchroniser
  task automatic t_status();
    // release the strobe so the printer stops pulsing busy and ack
    wr_ctrl(5'h00);
    cyc(10);
    for (int k = 0; k < 16; k++) begin
      @(posedge core_clk_in);
      {hold, paper_out_in, printer_online_in, printer_fault_in} <= 4'(k);
      cyc(6);
      @(negedge core_clk_in);
      chk(status_out, {!busy_in, printer_ack_in, paper_out_in, printer_online_in,
          printer_fault_in, 3'h0});
    end
  endtask
  // fill against a busy printer, then stretch an EPP cycle
  task automatic t_fill();
    wr_ctrl(5'h04);
    n = 0;
    repeat (40) begin
      @(posedge core_clk_in);
      if (tx_valid_in && tx_ready_out) n++;
      tx_valid_in <= 1'b1;
      tx_data_in  <= 8'(8'h30 + n);
    end
    @(posedge core_clk_in);
    if (tx_ready_out) n++;
    tx_valid_in   <= 1'b0;
    port_mode_in  <= 2'h1;
    host_cycle_in <= 1'b1;
    chk(8'(n), 8'h11);
    cyc(3);
    @(negedge core_clk_in);
    chk({2'h0, channel_ready_oe_out, channel_ready_out, printer_select_out, printer_init_out,
         auto_line_feed_out, data_strobe_out}, 8'h2b);
    // ECP mode: alternate pins, no stretch
    @(posedge core_clk_in);
    port_mode_in  <= 2'h2;
    cyc(3);
    @(negedge core_clk_in);
    chk({3'h0, channel_ready_oe_out, printer_select_out, printer_init_out,
         auto_line_feed_out, data_strobe_out}, 8'h0b);
    @(posedge core_clk_in);
    port_mode_in  <= 2'h0;
    host_cycle_in <= 1'b0;
    cyc(3);
    @(negedge core_clk_in);
    chk({3'h0, channel_ready_oe_out, printer_select_out, printer_init_out,
         auto_line_feed_out, data_strobe_out}, 8'h0f);
  endtask
  // drain in order while the printer stalls after each strobe
  task automatic t_drain();
    @(posedge core_clk_in);
    hold <= 1'b0;
    for (int j = 0; j < 17; j++) begin
      n = 0;
      while (port_data_lines_out !== 8'(8'h30 + j) && n < 20) begin
        @(negedge core_clk_in);
        n++;
      end
      chk(port_data_lines_out, 8'(8'h30 + j));
      wr_ctrl(5'h05);
      cyc(4);
      wr_ctrl(5'h04);
      n = 0;
      do begin
        @(negedge core_clk_in);
        n++;
      end while (busy_in && n < 30);
    end
    chk({7'h0, tx_ready_out}, 8'h01);
  endtask
  // the printer drives the lines while the port listens
  task automatic t_rx();
    wr_ctrl(5'h14);
    foreach (pat[i]) begin
      @(posedge core_clk_in);
      drive_byte <= pat[i];
      cyc(4);
      @(negedge core_clk_in);
      chk(rx_data_out, pat[i]);
      chk({7'h0, port_data_lines_oe_out}, 8'h00);
    end
  endtask
  initial begin
    cyc(4);
    resetn_in <= 1'b1;
    t_ctrl_pins();
    t_status();
    t_fill();
    t_drain();
    t_rx();
    give_verdict();
  end
endmodule
`default_nettype wire
